// *** pimc_defs.vh ***
// Constants for the processor init and mode control block
`ifndef PIMC_DEFS_VH
`define PIMC_DEFS_VH

// Register offsets (byte addresses)
`define PIMC_OFF_CTRL0      8'h00
`define PIMC_OFF_CTRL4      8'h04
`define PIMC_OFF_ITB_BASE   8'h08
`define PIMC_OFF_ITB_LIMIT  8'h0c
`define PIMC_OFF_GTB_BASE   8'h10
`define PIMC_OFF_GTB_LIMIT  8'h14
`define PIMC_OFF_ACCUM      8'h18
`define PIMC_OFF_IDENT      8'h1c
`define PIMC_OFF_STATUS     8'h20
`define PIMC_OFF_CLEAR      8'h24
`define PIMC_OFF_ENABLE     8'h28
`define PIMC_OFF_SIMD_CSR   8'h2c

// Control register 0 fields
`define PIMC_CR0_PE         0
`define PIMC_CR0_NW         29
`define PIMC_CR0_CD         30

// Control register 4 fields
`define PIMC_CR4_OSSAVE     9
`define PIMC_CR4_OSFPEXC    10

// Feature flag word fields
`define PIMC_FEAT_FLUSH     19
`define PIMC_FEAT_XSAVE     24
`define PIMC_FEAT_SIMD1     25
`define PIMC_FEAT_SIMD2     26

// Identification leaf that returns the feature word
`define PIMC_IDENT_LEAF     32'h00000001

// Reset values
`define PIMC_RESET_FETCH    32'h0ffffff0
`define PIMC_RESET_ITB_BASE 32'h00000000
`define PIMC_RESET_ITB_LIM  16'h03ff
`define PIMC_REAL_ADDR_MASK 32'h000fffff

// Interrupt status bit positions
`define PIMC_IRQ_NMI        0
`define PIMC_IRQ_PROT       1
`define PIMC_IRQ_REAL       2
`define PIMC_IRQ_SIMDFP     3
`define PIMC_IRQ_BITS       4

`endif

// *** pimc_nmi_ctrl.v ***
// Non-maskable interrupt acceptance with nesting hold-off
`timescale 1ns/10ps
module pimc_nmi_ctrl
(
  input  wire clk,
  input  wire reset,
  input  wire nmiRequest,
  input  wire nmiDone,
  output reg  nmiTake,
  output reg  nmiInService
);

  reg prevRequest;
  reg pending;
  wire requestEdge;
  wire startNow;

  // Edge caught each cycle; level would retrigger on a held line
  assign requestEdge = nmiRequest & ~prevRequest;
  // A held-off request starts as soon as the running one ends
  assign startNow = (requestEdge | pending) & (~nmiInService | nmiDone);

  // Accept unless one is already held off; never nest a second one
  always @(posedge clk)
  begin
    if (reset)
    begin
      prevRequest  <= 1'b0;
      pending      <= 1'b0;
      nmiTake      <= 1'b0;
      nmiInService <= 1'b0;
    end
    else
    begin
      prevRequest <= nmiRequest;
      nmiTake     <= startNow;
      if (startNow)
        nmiInService <= 1'b1;
      else if (nmiDone)
        nmiInService <= 1'b0;
      // Only one request is remembered while one is serviced
      if (startNow)
        pending <= 1'b0;
      else if (requestEdge)
        pending <= 1'b1;
    end
  end

endmodule

// *** pimc_init_ctrl.v ***
// Processor reset, mode and system table register control
//
// Summary of operation
// - After reset the core is in real mode; first fetch at 0FFFFFF0h.
// - Real-mode interrupt table base resets to 0; table load replaces it.
// - Real mode addresses only the lowest 1 MByte of physical space.
// - Identification with accumulator 1 puts the feature word in data register.
// - Feature word bit 25 first SIMD, bit 26 second SIMD, bit 24 state save.
// - Feature word bit 19 reports cache-line flush support.
// - Control register 4 bit 9: OS supports SIMD state save and restore.
// - Control register 4 bit 10: OS handles SIMD floating-point exceptions.
// - Writing control register 0 bit 0 set enters protected mode.
// - Non-maskable interrupt taken unless one is already held off; not nested while one runs.
// - Global table register holds base and limit, loaded by its load instruction.
// - Interrupt table register holds base and limit, loaded by its load instruction.
// - Cache-disable and not-write-through set at reset, cleared only by software.
`timescale 1ns/10ps
`include "pimc_defs.vh"
module pimc_init_ctrl
#(
  parameter HAS_SIMD1 = 1'b1,
  parameter HAS_SIMD2 = 1'b1,
  parameter HAS_XSAVE = 1'b1,
  parameter HAS_FLUSH = 1'b1
)
(
  input  wire        clk,
  input  wire        reset,
  input  wire [7:0]  regAddr,
  input  wire [31:0] regWriteData,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [31:0] regReadData,
  input  wire [31:0] cpuAddr,
  input  wire        cpuAddrValid,
  output reg  [31:0] physAddr,
  output reg         realMode,
  output reg         cacheDisable,
  output reg         notWriteThrough,
  output reg         simdEnabled,
  input  wire        nmiRequest,
  input  wire        nmiDone,
  output reg         nmiTake,
  input  wire        simdFpFault,
  output reg         simdFpExceptionTake,
  output reg         simdFpFallback,
  output reg         irq
);

  reg  [31:0] controlReg0;
  reg  [31:0] controlReg4;
  reg  [31:0] interruptTableBase;
  reg  [15:0] interruptTableLimit;
  reg  [31:0] globalTableBase;
  reg  [15:0] globalTableLimit;
  reg  [31:0] accumulatorRegister;
  reg  [31:0] dataRegister;
  reg  [31:0] simdControlStatus;
  reg  [`PIMC_IRQ_BITS-1:0] irqStatus;
  reg  [`PIMC_IRQ_BITS-1:0] irqEnable;
  reg  [31:0] next_readData;
  reg  [`PIMC_IRQ_BITS-1:0] events;
  reg  [31:0] featureWord;
  wire [31:0] realAddr;
  wire        nmiTakeRaw;
  wire        peWrite;
  wire        ctrl4Write;
  wire        statusClear;
  wire        enableWrite;
  wire        identRun;
  wire        peNew;

  // Feature word is fixed by build options; unused bits read zero
  always @*
  begin
    featureWord                   = 32'h00000000;
    featureWord[`PIMC_FEAT_FLUSH] = HAS_FLUSH[0];
    featureWord[`PIMC_FEAT_XSAVE] = HAS_XSAVE[0];
    featureWord[`PIMC_FEAT_SIMD1] = HAS_SIMD1[0];
    featureWord[`PIMC_FEAT_SIMD2] = HAS_SIMD2[0];
  end

  // Write decode, one strobe each for control 0, control 4, clear, enable and identification writes
  assign peWrite     = regWrite && (regAddr == `PIMC_OFF_CTRL0);
  assign ctrl4Write  = regWrite && (regAddr == `PIMC_OFF_CTRL4);
  assign statusClear = regWrite && (regAddr == `PIMC_OFF_CLEAR);
  assign enableWrite = regWrite && (regAddr == `PIMC_OFF_ENABLE);
  assign identRun    = regWrite && (regAddr == `PIMC_OFF_IDENT);
  assign peNew       = regWriteData[`PIMC_CR0_PE];

  // Real mode sees only the low 1 MByte of the physical space
  assign realAddr = cpuAddr & `PIMC_REAL_ADDR_MASK;

  // NMI acceptance lives in its own module
  pimc_nmi_ctrl nmiCtrl
  (
    .clk          (clk),
    .reset        (reset),
    .nmiRequest   (nmiRequest),
    .nmiDone      (nmiDone),
    .nmiTake      (nmiTakeRaw),
    .nmiInService ()
  );

  // Control register 0; only mode and cache bits are writable
  always @(posedge clk)
  begin
    if (reset)
    begin
      controlReg0 <= 32'h00000000;
      controlReg0[`PIMC_CR0_CD] <= 1'b1;
      controlReg0[`PIMC_CR0_NW] <= 1'b1;
    end
    else if (peWrite)
    begin
      controlReg0[`PIMC_CR0_PE] <= regWriteData[`PIMC_CR0_PE];
      controlReg0[`PIMC_CR0_CD] <= regWriteData[`PIMC_CR0_CD];
      controlReg0[`PIMC_CR0_NW] <= regWriteData[`PIMC_CR0_NW];
    end
  end

  // Control register 4; only the two OS support flags are writable
  always @(posedge clk)
  begin
    if (reset)
      controlReg4 <= 32'h00000000;
    else if (ctrl4Write)
    begin
      controlReg4[`PIMC_CR4_OSSAVE]  <= regWriteData[`PIMC_CR4_OSSAVE];
      controlReg4[`PIMC_CR4_OSFPEXC] <= regWriteData[`PIMC_CR4_OSFPEXC];
    end
  end

  // Table, SIMD control and accumulator registers; a table write stands for its load instruction
  always @(posedge clk)
  begin
    if (reset)
    begin
      interruptTableBase  <= `PIMC_RESET_ITB_BASE;
      interruptTableLimit <= `PIMC_RESET_ITB_LIM;
      globalTableBase     <= 32'h00000000;
      globalTableLimit    <= 16'h0000;
      simdControlStatus   <= 32'h00000000;
      accumulatorRegister <= 32'h00000000;
    end
    else if (regWrite)
    begin
      case (regAddr)
        `PIMC_OFF_ITB_BASE:  interruptTableBase  <= regWriteData;
        `PIMC_OFF_ITB_LIMIT: interruptTableLimit <= regWriteData[15:0];
        `PIMC_OFF_GTB_BASE:  globalTableBase     <= regWriteData;
        `PIMC_OFF_GTB_LIMIT: globalTableLimit    <= regWriteData[15:0];
        `PIMC_OFF_SIMD_CSR:  simdControlStatus   <= regWriteData;
        `PIMC_OFF_ACCUM:     accumulatorRegister <= regWriteData;
        default: ;
      endcase
    end
  end

  // Identification runs on a write; unknown leaves answer zero, not a stale word
  always @(posedge clk)
  begin
    if (reset)
      dataRegister <= 32'h00000000;
    else if (identRun)
    begin
      if (accumulatorRegister == `PIMC_IDENT_LEAF)
        dataRegister <= featureWord;
      else
        dataRegister <= 32'h00000000;
    end
  end

  // Address path; first fetch goes to the reset vector
  always @(posedge clk)
  begin
    if (reset)
      physAddr <= `PIMC_RESET_FETCH;
    else if (cpuAddrValid)
      physAddr <= realMode ? realAddr : cpuAddr;
  end

  // Mode and cache outputs; mode follows the write at once
  always @(posedge clk)
  begin
    if (reset)
    begin
      realMode        <= 1'b1;
      cacheDisable    <= 1'b1;
      notWriteThrough <= 1'b1;
      simdEnabled     <= 1'b0;
    end
    else
    begin
      if (peWrite)
      begin
        realMode        <= ~peNew;
        cacheDisable    <= regWriteData[`PIMC_CR0_CD];
        notWriteThrough <= regWriteData[`PIMC_CR0_NW];
      end
      simdEnabled <= controlReg4[`PIMC_CR4_OSSAVE];
    end
  end

  // SIMD fault goes to the handler only when the OS declared it handles it
  always @(posedge clk)
  begin
    if (reset)
    begin
      simdFpExceptionTake <= 1'b0;
      simdFpFallback      <= 1'b0;
    end
    else
    begin
      simdFpExceptionTake <= simdFpFault & controlReg4[`PIMC_CR4_OSFPEXC];
      simdFpFallback      <= simdFpFault & ~controlReg4[`PIMC_CR4_OSFPEXC];
    end
  end

  // Port copy of the NMI take, so the output comes from a flop here
  always @(posedge clk)
  begin
    if (reset)
      nmiTake <= 1'b0;
    else
      nmiTake <= nmiTakeRaw;
  end

  // Events for the sticky status register
  always @*
  begin
    events = {`PIMC_IRQ_BITS{1'b0}};
    events[`PIMC_IRQ_NMI]    = nmiTakeRaw;
    events[`PIMC_IRQ_PROT]   = peWrite & peNew & realMode;
    events[`PIMC_IRQ_REAL]   = peWrite & ~peNew & ~realMode;
    events[`PIMC_IRQ_SIMDFP] = simdFpFault & controlReg4[`PIMC_CR4_OSFPEXC];
  end

  // Sticky status; a new event beats a clear in the same cycle
  always @(posedge clk)
  begin
    if (reset)
      irqStatus <= {`PIMC_IRQ_BITS{1'b0}};
    else if (statusClear)
      irqStatus <= (irqStatus & ~regWriteData[`PIMC_IRQ_BITS-1:0]) | events;
    else
      irqStatus <= irqStatus | events;
  end

  // Enable mask has the same layout as status
  always @(posedge clk)
  begin
    if (reset)
      irqEnable <= {`PIMC_IRQ_BITS{1'b0}};
    else if (enableWrite)
      irqEnable <= regWriteData[`PIMC_IRQ_BITS-1:0];
  end

  // Level output; one cycle behind status so it comes from a flop
  always @(posedge clk)
  begin
    if (reset)
      irq <= 1'b0;
    else
      irq <= |(irqStatus & irqEnable);
  end

  // Read mux; unmapped and write-only offsets read zero
  always @*
  begin
    next_readData = 32'h00000000;
    case (regAddr)
      `PIMC_OFF_CTRL0:     next_readData = controlReg0;
      `PIMC_OFF_CTRL4:     next_readData = controlReg4;
      `PIMC_OFF_ITB_BASE:  next_readData = interruptTableBase;
      `PIMC_OFF_ITB_LIMIT: next_readData = {16'h0000, interruptTableLimit};
      `PIMC_OFF_GTB_BASE:  next_readData = globalTableBase;
      `PIMC_OFF_GTB_LIMIT: next_readData = {16'h0000, globalTableLimit};
      `PIMC_OFF_ACCUM:     next_readData = accumulatorRegister;
      `PIMC_OFF_IDENT:     next_readData = dataRegister;
      `PIMC_OFF_STATUS:    next_readData = {{(32-`PIMC_IRQ_BITS){1'b0}}, irqStatus};
      `PIMC_OFF_ENABLE:    next_readData = {{(32-`PIMC_IRQ_BITS){1'b0}}, irqEnable};
      `PIMC_OFF_SIMD_CSR:  next_readData = simdControlStatus;
      default:             next_readData = 32'h00000000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk)
  begin
    if (reset)
      regReadData <= 32'h00000000;
    else if (regRead)
      regReadData <= next_readData;
    else
      regReadData <= 32'h00000000;
  end

endmodule

// *** pimc_init_props.sv ***
// Port-level checks for the init and mode control block
`timescale 1ns/10ps
module pimc_init_props
(
  input wire        clk,
  input wire        reset,
  input wire [7:0]  regAddr,
  input wire [31:0] regWriteData,
  input wire        regWrite,
  input wire        regRead,
  input wire [31:0] regReadData,
  input wire [31:0] cpuAddr,
  input wire        cpuAddrValid,
  input wire [31:0] physAddr,
  input wire        realMode,
  input wire        cacheDisable,
  input wire        notWriteThrough,
  input wire        simdEnabled,
  input wire        nmiRequest,
  input wire        nmiDone,
  input wire        nmiTake,
  input wire        simdFpFault,
  input wire        simdFpExceptionTake,
  input wire        simdFpFallback
);
  reg        prevReq;
  reg        busy;
  reg        pend;
  reg        fpOn;
  wire       rise = nmiRequest && !prevReq;
  wire       wr0  = regWrite && regAddr == 8'h00;
  wire       wr4  = regWrite && regAddr == 8'h04;
  wire       wd0  = regWriteData[0];
  wire       wd9  = regWriteData[9];
  wire [1:0] cdNw = regWriteData[30:29];
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Shadow of NMI service; one pending edge kept so nesting stays tracked
  always @(posedge clk)
  begin
    if (reset)
    begin
      prevReq <= 1'b0;
      busy <= 1'b0;
      pend <= 1'b0;
      fpOn <= 1'b0;
    end
    else
    begin
      prevReq <= nmiRequest;
      if (wr4)
        fpOn <= regWriteData[10];
      if (nmiDone)
      begin
        busy <= pend | rise;
        pend <= 1'b0;
      end
      else if (rise && busy)
        pend <= 1'b1;
      else if (rise)
        busy <= 1'b1;
    end
  end
  a_reset_state: assert property ($fell(reset) |-> physAddr == 32'h0ffffff0 && realMode
    && cacheDisable && notWriteThrough && !simdEnabled) else $error("reset state wrong");
  a_real_mask: assert property (cpuAddrValid && realMode && !wr0 |=>
    physAddr == ($past(cpuAddr) & 32'h000fffff)) else $error("real mode address not masked");
  a_mode_switch: assert property (wr0 |=> realMode == !$past(wd0)) else $error("mode not switched");
  a_cache_hold: assert property (!wr0 |=> $stable(cacheDisable) && $stable(notWriteThrough))
    else $error("cache flags moved without write");
  a_cache_write: assert property (wr0 |=> {cacheDisable, notWriteThrough} == $past(cdNw))
    else $error("cache flags not written");
  a_simd_delay: assert property (wr4 |=> ##1 simdEnabled == $past(wd9, 2)) else $error("simd flag wrong");
  a_fp_route: assert property (simdFpFault |=> simdFpExceptionTake == $past(fpOn)
    && simdFpFallback == !$past(fpOn)) else $error("fp fault routed wrong");
  a_nmi_accept: assert property (rise && !busy && !nmiDone |-> ##2 nmiTake) else $error("nmi not taken");
  a_nmi_hold: assert property (rise && busy && !nmiDone |-> ##2 !nmiTake) else $error("nmi nested");
  a_nmi_pulse: assert property (nmiTake |=> !nmiTake) else $error("nmi take too long");
  a_read_idle: assert property (!$past(regRead) |-> regReadData == 32'h0) else $error("stray read data");
endmodule

bind pimc_init_ctrl pimc_init_props i_props (.clk, .reset, .regAddr, .regWriteData, .regWrite, .regRead,
  .regReadData, .cpuAddr, .cpuAddrValid, .physAddr, .realMode, .cacheDisable, .notWriteThrough, .simdEnabled,
  .nmiRequest, .nmiDone, .nmiTake, .simdFpFault, .simdFpExceptionTake, .simdFpFallback);

// *** tb.sv ***
// Self-checking bench for the init and mode control block
`timescale 1ns/10ps
module tb;
  reg         clk;
  reg         reset;
  reg  [7:0]  regAddr;
  reg  [31:0] regWriteData;
  reg         regWrite;
  reg         regRead;
  wire [31:0] regReadData;
  reg  [31:0] cpuAddr;
  reg         cpuAddrValid;
  wire [31:0] physAddr;
  wire        realMode;
  wire        cacheDisable;
  wire        notWriteThrough;
  wire        simdEnabled;
  reg         nmiRequest;
  reg         nmiGate;
  reg         nmiDone;
  wire        nmiTake;
  reg         simdFpFault;
  wire        simdFpExceptionTake;
  wire        simdFpFallback;
  wire        irq;
  integer     fails;
  integer     checked;
  integer     seed;
  integer     i;
  reg  [31:0] v;
  reg  [7:0]  a;

  pimc_init_ctrl i_dut (.clk, .reset, .regAddr, .regWriteData, .regWrite, .regRead, .regReadData, .cpuAddr,
    .cpuAddrValid, .physAddr, .realMode, .cacheDisable, .notWriteThrough, .simdEnabled, .nmiRequest, .nmiDone,
    .nmiTake, .simdFpFault, .simdFpExceptionTake, .simdFpFallback, .irq);

  // Free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
  begin
    checked = checked + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("BAD %0s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask

  // Expected physical address for a core address in either mode
  function [31:0] physExp(input [31:0] ca, input rm);
  begin
    physExp = rm ? (ca & 32'h000fffff) : ca;
  end
  endfunction

  task results;
  begin
    $display("fails %0d checked %0d", fails, checked);
    if (fails == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask

  // Bus tasks; strobes drop on the edge that takes them
  task wr(input [7:0] ad, input [31:0] d);
  begin
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= ad;
    regWriteData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    #1;
  end
  endtask

  task rd(input [7:0] ad, input [31:0] e);
  begin
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= ad;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk("read", regReadData, e);
  end
  endtask

  task addr(input [31:0] ca, input [31:0] e);
  begin
    @(posedge clk);
    cpuAddr <= ca;
    cpuAddrValid <= 1'b1;
    @(posedge clk);
    cpuAddrValid <= 1'b0;
    #1 chk("phys", physAddr, e);
  end
  endtask

  task pulse(input integer w);
  begin
    @(posedge clk);
    if (w == 0) simdFpFault <= 1'b1; else nmiDone <= 1'b1;
    @(posedge clk);
    simdFpFault <= 1'b0;
    nmiDone <= 1'b0;
    #1;
  end
  endtask

  // Bounded watch for an NMI take; a missing one ends the run
  task nmiWait(input e);
    reg got;
  begin
    got = 1'b0;
    repeat (4) @(posedge clk) #1 if (nmiTake === 1'b1) got = 1'b1;
    chk("nmi", {31'h0, got}, {31'h0, e});
    if (e && !got) results;
  end
  endtask

  initial
  begin
    {regAddr, regWriteData, regWrite, regRead, cpuAddr, cpuAddrValid} = 0;
    {nmiRequest, nmiDone, simdFpFault, nmiGate} = 4'h0;
    reset = 1'b1;
    fails = 0;
    checked = 0;
    seed = 32'heb90;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    #1 chk("fetch", physAddr, 32'h0ffffff0);
    chk("real", {31'h0, realMode}, 32'h1);
    rd(8'h00, 32'h60000000);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h0c, 32'h3ff);
    rd(8'h30, 32'h0);
    wr(8'h18, 32'h1);
    wr(8'h1c, 32'h0);
    rd(8'h1c, 32'h07080000);
    v = $random(seed) | 32'h2;
    wr(8'h18, v);
    wr(8'h1c, v);
    rd(8'h1c, 32'h0);
    for (i = 0; i < 4; i = i + 1)
    begin
      v = $random(seed);
      a = 8'h08 + 8'h04 * i[7:0];
      wr(a, v);
      rd(a, i[0] ? v & 32'hffff : v);
    end
    v = $random(seed);
    wr(8'h2c, v);
    rd(8'h2c, v);
    wr(8'h14, 32'h17);
    rd(8'h14, 32'h17);
    for (i = 0; i < 8; i = i + 1)
    begin
      v = (i == 0) ? 32'hffffffff : $random(seed);
      addr(v, physExp(v, 1'b1));
    end
    wr(8'h04, 32'hffffffff);
    rd(8'h04, 32'h600);
    chk("simd", {31'h0, simdEnabled}, 32'h1);
    pulse(0);
    chk("fpexc", {30'h0, simdFpExceptionTake, simdFpFallback}, 32'h2);
    wr(8'h04, 32'h200);
    pulse(0);
    chk("fpfb", {30'h0, simdFpExceptionTake, simdFpFallback}, 32'h1);
    wr(8'h0c, 32'hff);
    rd(8'h0c, 32'hff);
    wr(8'h28, 32'h2);
    wr(8'h00, 32'h1);
    chk("mode", {29'h0, realMode, cacheDisable, notWriteThrough}, 32'h0);
    rd(8'h20, 32'ha);
    chk("irq", {31'h0, irq}, 32'h1);
    v = $random(seed);
    addr(v, physExp(v, 1'b0));
    wr(8'h20, 32'h0);
    wr(8'h24, 32'h2);
    rd(8'h20, 32'h8);
    wr(8'h00, 32'h0);
    rd(8'h28, 32'h2);
    chk("mask", {30'h0, irq, realMode}, 32'h1);
    wr(8'h28, 32'h4);
    rd(8'h24, 32'h0);
    chk("irq", {31'h0, irq}, 32'h1);
    @(posedge clk) nmiRequest <= nmiGate;
    nmiWait(1'b0);
    nmiGate = 1'b1;
    @(posedge clk) nmiRequest <= nmiGate;
    nmiWait(1'b1);
    @(posedge clk) nmiRequest <= 1'b0;
    @(posedge clk) nmiRequest <= 1'b1;
    nmiWait(1'b0);
    pulse(1);
    nmiWait(1'b1);
    rd(8'h20, 32'hd);
    pulse(1);
    @(posedge clk) reset <= 1'b1;
    nmiGate = 1'b0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1 chk("fetch", physAddr, 32'h0ffffff0);
    chk("rst", {27'h0, realMode, cacheDisable, notWriteThrough, simdEnabled, irq}, 32'h1c);
    rd(8'h04, 32'h0);
    results;
  end
endmodule
